// ===== hdl/mit_channel.sv
// one 8-bit modulo interval timer channel with gated counting and match pulse
`timescale 1ns/100ps
`default_nettype none
`include "mit_map.svh"

module mit_channel
  import mit_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control from the register side
  input wire logic soft_reset,
  input wire logic [3:0] base_tick,
  input wire mit_ctl_s ctl,
  input wire logic clear_req,
  input wire logic gate_open,
  input wire logic [7:0] modulo,
  // results
  output logic [7:0] count,
  output logic match_irq
);

  mit_chan_s state;
  mit_chan_s next_state;
  logic tick;
  logic [7:0] next_count_inc;

  // the base ticks run free, so enabling may add and disabling may lose one tick
  assign tick = base_tick[ctl.base_sel] & ctl.run & gate_open; // R12 R14 R15

  // count, match and auto clear
  always_comb
  begin
    next_state = state;
    next_state.irq = 1'h0;
    next_count_inc = 8'(state.count + 8'h01); // R5
    if (soft_reset || clear_req)
    begin
      // a clear drops any tick of the same cycle, hence up to one tick of extra period
      next_state.count = `MIT_COUNT_RST; // R13
    end
    else if (tick)
    begin
      if (next_count_inc == modulo)
      begin
        next_state.count = `MIT_COUNT_RST; // R7
        next_state.irq = 1'h1; // R6
      end
      else
      begin
        next_state.count = next_count_inc; // R2
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= '{count: `MIT_COUNT_RST, irq: 1'h0};
    else
      state <= next_state;
  end

  assign count = state.count;
  assign match_irq = state.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_IRQ_CLEARS: // R7
  assert property (match_irq |-> count == 8'h00)
    else $error("match pulse without counter cleared");
  AST_IRQ_CAUSE: // R6
  assert property (match_irq |-> $past(tick) && $past(next_count_inc) == $past(modulo) && !$past(clear_req))
    else $error("match pulse without a matching tick");
  AST_IRQ_PULSE: // R16
  assert property (match_irq |=> !match_irq)
    else $error("match pulse longer than one cycle");
  AST_GATE_HALT: // R15
  assert property ((!gate_open || !ctl.run) && !clear_req && !soft_reset |=> count == $past(count))
    else $error("counter moved while gate shut or stopped");

endmodule
`default_nettype wire

// ===== hdl/mit_map.svh
// register offsets, field positions, reset values and timing counts of the interval timers
`ifndef MIT_MAP_SVH
`define MIT_MAP_SVH

// flag register offsets (4-bit control registers)
`define MIT_OFS_T2_CTL 7'h29
`define MIT_OFS_T1_CTL 7'h2A

// peripheral offsets reached through the transfer buffer
`define MIT_OFS_T2_COUNT 7'h1F
`define MIT_OFS_T1_COUNT 7'h1E
`define MIT_OFS_T1_MOD 7'h1C
`define MIT_OFS_T2_MOD 7'h1D

// control register field positions
`define MIT_RUN_BIT 3
`define MIT_CLR_BIT 2
`define MIT_SEL_LSB 0

// reset values
`define MIT_CTL_RST 4'h0
`define MIT_COUNT_RST 8'h00
`define MIT_MOD_RST 8'hFF

// time base periods in ns and their cycle counts at the system clock
`define MIT_CLK_MHZ 25
`define MIT_PER_100K_NS 10000
`define MIT_PER_10K_NS 100000
`define MIT_PER_2K_NS 500000
`define MIT_PER_1K_NS 1000000
`define MIT_CYC_100K (`MIT_PER_100K_NS * `MIT_CLK_MHZ / 1000)
`define MIT_CYC_10K (`MIT_PER_10K_NS * `MIT_CLK_MHZ / 1000)
`define MIT_CYC_2K (`MIT_PER_2K_NS * `MIT_CLK_MHZ / 1000)
`define MIT_CYC_1K (`MIT_PER_1K_NS * `MIT_CLK_MHZ / 1000)

`endif

// ===== hdl/mit_pkg.sv
// types shared by the interval timer files
`default_nettype none
package mit_pkg;

  // one 4-bit control register, bit 3 down to bit 0
  typedef struct packed {
    logic run;
    logic count_clear;
    logic [1:0] base_sel;
  } mit_ctl_s;

  // flag register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [3:0] wdata;
  } mit_flag_req_s;

  typedef struct packed {
    logic valid;
    logic [3:0] rdata;
  } mit_flag_rsp_s;

  // transfer buffer put/get access
  typedef struct packed {
    logic put;
    logic get;
    logic [6:0] addr;
    logic [7:0] transfer_buffer;
  } mit_xfer_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] transfer_buffer;
  } mit_xfer_rsp_s;

  // state of one timer channel
  typedef struct packed {
    logic [7:0] count;
    logic irq;
  } mit_chan_s;

  // state of the top level
  typedef struct packed {
    logic [3:0][14:0] presc;
    logic [3:0] tick;
    mit_ctl_s ctl1;
    mit_ctl_s ctl2;
    logic [7:0] mod1;
    logic [7:0] mod2;
    logic clr1;
    logic clr2;
    mit_flag_rsp_s frsp;
    mit_xfer_rsp_s drsp;
  } mit_top_s;

endpackage
`default_nettype wire

// ===== hdl/mit_top.sv
// two 8-bit modulo interval timers sharing four free-running time bases
`timescale 1ns/100ps
`default_nettype none
`include "mit_map.svh"

// Contract
// R1: base select 00/01/10/11 picks 100 kHz, 10 kHz, 2 kHz, 1 kHz.
// R2: run bit 3 set lets ticks into the counter; clear halts counting.
// R3: writing 1 to bit 2 clears the counter; writing 0 leaves it.
// R4: bit 2 of a control register always reads back as 0.
// R5: an 8-bit up counter counts ticks and compares on each count.
// R6: counter reaching the modulo value raises the interrupt request.
// R7: counter reaching the modulo value is cleared to zero automatically.
// R8: software reads the count through the buffer and never writes it.
// R9: a modulo value put through the buffer is used for later compares.
// R10: power-on and watchdog reset clear control bits; CE reset keeps them.
// R11: power-on and watchdog reset clear the count; CE reset keeps it.
// R12: start may add one tick, stop may lose one tick of period.
// R13: a software clear may lengthen the first period by one tick.
// R14: new base takes effect at once; first tick up to one period late.
// R15: gated counting needs both the gate open and the run bit set.
// R16: each match gives a one-cycle interrupt pulse on the system clock.
module mit_top
  import mit_pkg::*;
#(
  parameter int unsigned BASE_CYC0 = `MIT_CYC_100K,
  parameter int unsigned BASE_CYC1 = `MIT_CYC_10K,
  parameter int unsigned BASE_CYC2 = `MIT_CYC_2K,
  parameter int unsigned BASE_CYC3 = `MIT_CYC_1K
)
(
  // clock and resets
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wdt_reset,
  // flag register access
  input wire mit_flag_req_s flag_req,
  output mit_flag_rsp_s flag_rsp,
  // transfer buffer access
  input wire mit_xfer_req_s xfer_req,
  output mit_xfer_rsp_s xfer_rsp,
  // external gates, bit 0 first timer, bit 1 second timer
  input wire logic [1:0] gate_open,
  // interrupt requests, bit 0 first timer, bit 1 second timer
  output logic [1:0] irq_req
);

  // 15-bit prescalers; a one-cycle base would let the match pulses of a channel run together
  if (BASE_CYC0 < 2 || BASE_CYC0 > 32767 || BASE_CYC1 < 2 || BASE_CYC1 > 32767 ||
      BASE_CYC2 < 2 || BASE_CYC2 > 32767 || BASE_CYC3 < 2 || BASE_CYC3 > 32767)
  begin : g_bad_base
    $error("time base cycle count out of range 2..32767");
  end

  mit_top_s state;
  mit_top_s next_state;
  logic [7:0] count1;
  logic [7:0] count2;
  logic irq1;
  logic irq2;

  // last prescaler value of each time base
  function automatic logic [14:0] base_last(input int idx);
    logic [14:0] last;
    case (idx)
      0: last = 15'(BASE_CYC0 - 1);
      1: last = 15'(BASE_CYC1 - 1);
      2: last = 15'(BASE_CYC2 - 1);
      default: last = 15'(BASE_CYC3 - 1);
    endcase
    return last;
  endfunction

  // stored form of a control write; the clear bit is a strobe and never stored
  function automatic mit_ctl_s ctl_store(input logic [3:0] wdata);
    mit_ctl_s c;
    c.run = wdata[`MIT_RUN_BIT];
    c.count_clear = 1'h0;
    c.base_sel = wdata[`MIT_SEL_LSB +: 2];
    return c;
  endfunction

  // next state of the whole top level
  always_comb
  begin
    next_state = state;
    next_state.clr1 = 1'h0;
    next_state.clr2 = 1'h0;

    // free-running dividers; not aligned to enable, clear or select changes
    for (int i = 0; i < 4; i++)
    begin
      next_state.tick[i] = 1'h0;
      if (state.presc[i] == base_last(i))
      begin
        next_state.presc[i] = 15'h0000;
        next_state.tick[i] = 1'h1; // R1
      end
      else
      begin
        next_state.presc[i] = 15'(state.presc[i] + 15'h0001);
      end
    end

    // control register writes; a select change acts on the very next tick of the new base
    if (flag_req.wr)
    begin
      case (flag_req.addr)
        `MIT_OFS_T1_CTL:
        begin
          next_state.ctl1 = ctl_store(flag_req.wdata); // R14
          next_state.clr1 = flag_req.wdata[`MIT_CLR_BIT]; // R3
        end
        `MIT_OFS_T2_CTL:
        begin
          next_state.ctl2 = ctl_store(flag_req.wdata); // R12
          next_state.clr2 = flag_req.wdata[`MIT_CLR_BIT]; // R3
        end
        default:
        begin
          next_state.clr1 = 1'h0;
        end
      endcase
    end

    // control register reads, registered; unmapped offsets read zero
    next_state.frsp.valid = flag_req.rd;
    case (flag_req.addr)
      `MIT_OFS_T1_CTL: next_state.frsp.rdata = state.ctl1; // R4
      `MIT_OFS_T2_CTL: next_state.frsp.rdata = state.ctl2; // R4
      default: next_state.frsp.rdata = 4'h0;
    endcase

    // modulo loads; a put aimed at a counter is ignored so the count stays intact
    if (xfer_req.put)
    begin
      case (xfer_req.addr)
        `MIT_OFS_T1_MOD: next_state.mod1 = xfer_req.transfer_buffer; // R9
        `MIT_OFS_T2_MOD: next_state.mod2 = xfer_req.transfer_buffer; // R9
        default: next_state.mod1 = state.mod1; // R8
      endcase
    end

    // buffer reads of count and modulo, registered
    next_state.drsp.valid = xfer_req.get;
    case (xfer_req.addr)
      `MIT_OFS_T1_COUNT: next_state.drsp.transfer_buffer = count1; // R8
      `MIT_OFS_T2_COUNT: next_state.drsp.transfer_buffer = count2; // R8
      `MIT_OFS_T1_MOD: next_state.drsp.transfer_buffer = state.mod1;
      `MIT_OFS_T2_MOD: next_state.drsp.transfer_buffer = state.mod2;
      default: next_state.drsp.transfer_buffer = 8'h00;
    endcase

    // watchdog reset wins over any control write or modulo put of the same cycle
    if (wdt_reset)
    begin
      next_state.ctl1 = `MIT_CTL_RST; // R10
      next_state.ctl2 = `MIT_CTL_RST; // R10
      next_state.clr1 = 1'h0;
      next_state.clr2 = 1'h0;
      next_state.mod1 = `MIT_MOD_RST;
      next_state.mod2 = `MIT_MOD_RST;
    end
  end

  // power-on reset puts everything to constants
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '0;
      state.ctl1 <= `MIT_CTL_RST; // R10
      state.ctl2 <= `MIT_CTL_RST;
      state.mod1 <= `MIT_MOD_RST;
      state.mod2 <= `MIT_MOD_RST;
    end
    else
    begin
      state <= next_state;
    end
  end

  // first timer
  mit_channel u_first
  (
    .clk(clk),
    .reset_n(reset_n),
    .soft_reset(wdt_reset), // R11
    .base_tick(state.tick),
    .ctl(state.ctl1),
    .clear_req(state.clr1),
    .gate_open(gate_open[0]),
    .modulo(state.mod1),
    .count(count1),
    .match_irq(irq1)
  );

  // second timer
  mit_channel u_second
  (
    .clk(clk),
    .reset_n(reset_n),
    .soft_reset(wdt_reset), // R11
    .base_tick(state.tick),
    .ctl(state.ctl2),
    .clear_req(state.clr2),
    .gate_open(gate_open[1]),
    .modulo(state.mod2),
    .count(count2),
    .match_irq(irq2)
  );

  // outputs straight from flip-flops
  assign flag_rsp = state.frsp;
  assign xfer_rsp = state.drsp;
  assign irq_req = {irq2, irq1}; // R16

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // a control write to the first timer with the clear bit set
  sequence s_clear_write1;
    flag_req.wr && flag_req.addr == `MIT_OFS_T1_CTL && flag_req.wdata[`MIT_CLR_BIT] && !wdt_reset;
  endsequence

  // a modulo put to the second timer
  sequence s_mod_put2;
    xfer_req.put && xfer_req.addr == `MIT_OFS_T2_MOD && !wdt_reset;
  endsequence

  // a modulo put to the first timer
  sequence s_mod_put1;
    xfer_req.put && xfer_req.addr == `MIT_OFS_T1_MOD && !wdt_reset;
  endsequence

  // a put aimed at either counter, which must change nothing
  sequence s_count_put;
    xfer_req.put && (xfer_req.addr == `MIT_OFS_T1_COUNT || xfer_req.addr == `MIT_OFS_T2_COUNT) && !wdt_reset;
  endsequence

  // a count get of the second timer
  sequence s_count_get2;
    xfer_req.get && xfer_req.addr == `MIT_OFS_T2_COUNT;
  endsequence

  // a count get of the first timer
  sequence s_count_get1;
    xfer_req.get && xfer_req.addr == `MIT_OFS_T1_COUNT;
  endsequence

  // a control write to the second timer with the clear bit set
  sequence s_clear_write2;
    flag_req.wr && flag_req.addr == `MIT_OFS_T2_CTL && flag_req.wdata[`MIT_CLR_BIT] && !wdt_reset;
  endsequence

  // a control write to the first timer with the clear bit low
  sequence s_keep_write1;
    flag_req.wr && flag_req.addr == `MIT_OFS_T1_CTL && !flag_req.wdata[`MIT_CLR_BIT] && !wdt_reset;
  endsequence

  // any control write to the first timer
  sequence s_ctl_write1;
    flag_req.wr && flag_req.addr == `MIT_OFS_T1_CTL && !wdt_reset;
  endsequence

  AST_CLEAR_WRITE: // R3
  assert property (s_clear_write1 |=> state.clr1 ##1 count1 == 8'h00)
    else $error("clear write did not zero the first counter");
  AST_CLEAR_READS_ZERO: // R4
  assert property (flag_rsp.valid |-> !flag_rsp.rdata[`MIT_CLR_BIT])
    else $error("clear bit read back as one");
  AST_RUN_STORED: // R2
  assert property (flag_req.wr && flag_req.addr == `MIT_OFS_T2_CTL && !wdt_reset
                   |=> state.ctl2.run == $past(flag_req.wdata[`MIT_RUN_BIT]))
    else $error("run bit not stored");
  AST_WDT_CTL: // R10
  assert property (wdt_reset |=> state.ctl1 == 4'h0 && state.ctl2 == 4'h0)
    else $error("watchdog reset left control bits set");
  AST_WDT_COUNT: // R11
  assert property (wdt_reset |=> count1 == 8'h00 && count2 == 8'h00 && irq_req == 2'h0)
    else $error("watchdog reset left a count");
  AST_MOD_LOAD: // R9
  assert property (s_mod_put2 |=> state.mod2 == $past(xfer_req.transfer_buffer))
    else $error("modulo put not taken");
  AST_COUNT_GET: // R8
  assert property (s_count_get2 |=> xfer_rsp.valid && xfer_rsp.transfer_buffer == $past(count2))
    else $error("count get returned wrong value");
  AST_TICK_BASE: // R1
  assert property (state.tick[0] |-> $past(state.presc[0]) == base_last(0) && state.presc[0] == 15'h0000)
    else $error("fastest base tick out of step");

  // second timer clear, a clear bit written as zero, and no match pulse after a first timer clear
  AST_CLEAR_WRITE2: // R3
  assert property (s_clear_write2 |=> state.clr2 ##1 count2 == 8'h00)
    else $error("clear write did not zero the second counter");
  AST_ZERO_KEEPS: // R3
  assert property (s_keep_write1 |=> !state.clr1)
    else $error("zero in the clear bit raised a clear");
  AST_CLEAR_NO_IRQ: // R13
  assert property (state.clr1 |=> !irq_req[0])
    else $error("match pulse on the cycle of a counter clear");

  // a control write takes run and select at the very next edge
  AST_RUN_STORED1: // R2
  assert property (s_ctl_write1 |=> state.ctl1.run == $past(flag_req.wdata[`MIT_RUN_BIT]))
    else $error("first run bit not stored");
  AST_SEL_STORED: // R14
  assert property (s_ctl_write1 |=> state.ctl1.base_sel == $past(flag_req.wdata[`MIT_SEL_LSB +: 2]))
    else $error("base select not taken at once");

  // control reads answer exactly one cycle later, and only then
  AST_READ_ANSWER: // R4
  assert property (flag_req.rd |=> flag_rsp.valid)
    else $error("control read not answered next cycle");
  AST_NO_SPURIOUS_ANSWER: // R4
  assert property (!flag_req.rd |=> !flag_rsp.valid)
    else $error("control answer without a read");
  AST_READ_CTL1: // R4
  assert property (flag_req.rd && flag_req.addr == `MIT_OFS_T1_CTL
                   |=> flag_rsp.rdata == {$past(state.ctl1.run), 1'h0, $past(state.ctl1.base_sel)})
    else $error("first control register read back wrong");

  // first timer buffer traffic; counters never take a put
  AST_MOD_LOAD1: // R9
  assert property (s_mod_put1 |=> state.mod1 == $past(xfer_req.transfer_buffer))
    else $error("first modulo put not taken");
  AST_COUNT_PUT: // R8
  assert property (s_count_put |=> state.mod1 == $past(state.mod1) && state.mod2 == $past(state.mod2))
    else $error("put to a counter changed a modulo");
  AST_COUNT_GET1: // R8
  assert property (s_count_get1 |=> xfer_rsp.valid && xfer_rsp.transfer_buffer == $past(count1))
    else $error("first count get returned wrong value");

  // slower bases keep their own period; prescalers never pass their last value
  AST_TICK_BASE1: // R1
  assert property (state.tick[1] |-> $past(state.presc[1]) == base_last(1) && state.presc[1] == 15'h0000)
    else $error("second base tick out of step");
  AST_TICK_BASE2: // R1
  assert property (state.tick[2] |-> $past(state.presc[2]) == base_last(2) && state.presc[2] == 15'h0000)
    else $error("third base tick out of step");
  AST_TICK_BASE3: // R1
  assert property (state.tick[3] |-> $past(state.presc[3]) == base_last(3) && state.presc[3] == 15'h0000)
    else $error("slowest base tick out of step");
  AST_PRESC_BOUND: // R1
  assert property (state.presc[0] <= base_last(0) && state.presc[1] <= base_last(1) &&
                   state.presc[2] <= base_last(2) && state.presc[3] <= base_last(3))
    else $error("prescaler ran past its last value");

endmodule
`default_nettype wire

// ===== sim/mit_top_tb_top.sv
// self-checking testbench for the two modulo interval timers
`timescale 1ns/100ps
`default_nettype none
`include "mit_map.svh"

module mit_top_tb_top
  import mit_pkg::*;
;
  // shortened time bases keep the run brief
  localparam int C0 = 4;
  localparam int C1 = 6;
  localparam int C2 = 8;
  localparam int C3 = 10;
  int base_cyc [4] = '{C0, C1, C2, C3};
  logic clk;
  logic reset_n;
  logic wdt_reset;
  mit_flag_req_s flag_req;
  mit_flag_rsp_s flag_rsp;
  mit_xfer_req_s xfer_req;
  mit_xfer_rsp_s xfer_rsp;
  logic [1:0] gate_open;
  logic [1:0] irq_req;
  int bad_count;
  int checks;
  int cyc;
  int n;
  logic [7:0] v1;
  logic [7:0] v2;

  mit_top #(.BASE_CYC0(C0), .BASE_CYC1(C1), .BASE_CYC2(C2), .BASE_CYC3(C3)) dut (
    .clk(clk),
    .reset_n(reset_n),
    .wdt_reset(wdt_reset),
    .flag_req(flag_req),
    .flag_rsp(flag_rsp),
    .xfer_req(xfer_req),
    .xfer_rsp(xfer_rsp),
    .gate_open(gate_open),
    .irq_req(irq_req)
  );

  // 25 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic finish_test();
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a hang is cut short well after the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end

  task automatic cmp_ctl(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h got %h", what, exp, got);
    end
  endtask

  task automatic cmp_data(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h got %h", what, exp, got);
    end
  endtask

  // one-cycle strobes; answers are looked at mid-cycle, when settled
  task automatic flag_wr(input logic [6:0] a, input logic [3:0] d);
    @(posedge clk) flag_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) flag_req <= '0;
  endtask

  task automatic flag_chk(input logic [6:0] a, input logic [3:0] exp);
    @(posedge clk) flag_req <= '{1'b0, 1'b1, a, 4'h0};
    @(posedge clk) flag_req <= '0;
    @(negedge clk);
    cmp_ctl("ctl valid", 4'h1, {3'h0, flag_rsp.valid});
    cmp_ctl("ctl rdata", exp, flag_rsp.rdata);
  endtask

  // puts go to modulo registers only; the counters are never a put target
  task automatic put(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk) xfer_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) xfer_req <= '0;
  endtask

  task automatic get(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk) xfer_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) xfer_req <= '0;
    @(negedge clk);
    cmp_data("get valid", 8'h01, {7'h0, xfer_rsp.valid});
    d = xfer_rsp.transfer_buffer;
  endtask

  // cycles until the next match pulse, bounded
  task automatic wait_irq(input int b, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge clk);
      cnt++;
    end
    while (irq_req[b] !== 1'b1 && cnt < 300);
  endtask

  task automatic t_reset();
    flag_chk(`MIT_OFS_T1_CTL, `MIT_CTL_RST);
    flag_chk(`MIT_OFS_T2_CTL, `MIT_CTL_RST);
    get(`MIT_OFS_T2_COUNT, v1);
    cmp_data("count2", `MIT_COUNT_RST, v1);
  endtask

  task automatic t_ctl();
    flag_wr(`MIT_OFS_T1_CTL, 4'hF);
    flag_chk(`MIT_OFS_T1_CTL, 4'hB);
    flag_wr(`MIT_OFS_T2_CTL, 4'h6);
    flag_chk(`MIT_OFS_T2_CTL, 4'h2);
    flag_chk(7'h2B, 4'h0);
    flag_wr(`MIT_OFS_T1_CTL, 4'h0);
    flag_wr(`MIT_OFS_T2_CTL, 4'h0);
  endtask

  task automatic t_match();
    put(`MIT_OFS_T1_MOD, 8'h03);
    get(`MIT_OFS_T1_MOD, v1);
    cmp_data("mod1", 8'h03, v1);
    flag_wr(`MIT_OFS_T1_CTL, 4'hC);
    wait_irq(0, n);
    wait_irq(0, n);
    cmp_data("irq1 period", 8'(3 * C0), 8'(n));
    @(negedge clk);
    cmp_data("irq1 width", 8'h00, {7'h0, irq_req[0]});
  endtask

  task automatic t_stop();
    put(`MIT_OFS_T1_MOD, 8'hFF);
    repeat (40) @(posedge clk);
    flag_wr(`MIT_OFS_T1_CTL, 4'h0);
    get(`MIT_OFS_T1_COUNT, v1);
    repeat (20) @(posedge clk);
    get(`MIT_OFS_T1_COUNT, v2);
    cmp_data("halted count", v1, v2);
    flag_wr(`MIT_OFS_T1_CTL, 4'h0);
    get(`MIT_OFS_T1_COUNT, v2);
    cmp_data("count kept", v1, v2);
    flag_wr(`MIT_OFS_T1_CTL, 4'h4);
    get(`MIT_OFS_T1_COUNT, v2);
    cmp_data("count cleared", 8'h00, v2);
  endtask

  // closed gate holds the count even with run set
  task automatic t_gate();
    @(posedge clk) gate_open <= 2'b10;
    flag_wr(`MIT_OFS_T1_CTL, 4'hC);
    repeat (40) @(posedge clk);
    get(`MIT_OFS_T1_COUNT, v1);
    cmp_data("gated count", 8'h00, v1);
    @(posedge clk) gate_open <= 2'b11;
    repeat (40) @(posedge clk);
    get(`MIT_OFS_T1_COUNT, v1);
    cmp_data("open count", 8'h01, {7'h0, v1 >= 8 && v1 <= 12});
  endtask

  // each select code gives its own match period
  task automatic t_sel();
    put(`MIT_OFS_T2_MOD, 8'h02);
    for (int s = 0; s < 4; s++)
    begin
      flag_wr(`MIT_OFS_T2_CTL, {2'b11, 2'(s)});
      wait_irq(1, n);
      wait_irq(1, n);
      cmp_data("irq2 period", 8'(2 * base_cyc[s]), 8'(n));
    end
  endtask

  task automatic t_wdt();
    flag_wr(`MIT_OFS_T1_CTL, 4'hB);
    @(posedge clk) wdt_reset <= 1'b1;
    @(posedge clk) wdt_reset <= 1'b0;
    flag_chk(`MIT_OFS_T1_CTL, 4'h0);
    flag_chk(`MIT_OFS_T2_CTL, 4'h0);
    get(`MIT_OFS_T2_COUNT, v1);
    cmp_data("count2 wdt", 8'h00, v1);
    get(`MIT_OFS_T2_MOD, v1);
    cmp_data("mod2 wdt", `MIT_MOD_RST, v1);
    put(`MIT_OFS_T2_MOD, 8'h55);
    get(`MIT_OFS_T2_COUNT, v1);
    cmp_data("count2 put", 8'h00, v1);
    get(`MIT_OFS_T2_MOD, v1);
    cmp_data("mod2 put", 8'h55, v1);
  endtask

  // reset held three cycles, then the scenarios in turn
  initial
  begin
    reset_n = 1'b0;
    wdt_reset = 1'b0;
    flag_req = '0;
    xfer_req = '0;
    gate_open = 2'b11;
    bad_count = 0;
    checks = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_ctl();
    t_match();
    t_stop();
    t_gate();
    t_sel();
    t_wdt();
    finish_test();
  end
endmodule
`default_nettype wire
